/* hw/pcg_pkg.sv */
// Constants, field layouts and state records for the pin change interrupt block.
// Assumes one 125 MHz system clock and a classic Wishbone master with 32-bit data.
// Function
// - Rising-edge enable bit at 1 makes rising transitions on that pin change events.
// - Falling-edge enable bit at 1 makes falling transitions on that pin change events.
// - Enable bit at 0 means that edge direction neither raises events nor sets flags.
// - Rising edge on an enabled pin sets that pin's change flag.
// - Falling edge on an enabled pin sets that pin's change flag.
// - Any enabled edge sets the pin flag and the module change interrupt flag.
// - Hardware sets flags; software writes them, a written 0 clears until next edge.
// - Three 8-bit registers, bit n is pin n, all reset to zero.
package pcg_pkg;

	localparam int PORT_WIDTH = 8;
	localparam int ADR_WIDTH = 8;
	localparam int DAT_WIDTH = 32;

	////////////////////////////////////////////////////////////////////////////
	// Byte addresses of the register words
	localparam logic [7:0] ADR_RISE_EN = 8'h00;
	localparam logic [7:0] ADR_FALL_EN = 8'h04;
	localparam logic [7:0] ADR_FLAGS = 8'h08;
	localparam logic [7:0] ADR_IRQ_STATUS = 8'h0c;
	localparam logic [7:0] ADR_IRQ_MASK = 8'h10;

	// Status and mask layout
	localparam int IRQ_CHANGE_BIT = 0;

	// Clean samples needed before edges count: two sync stages and one previous sample
	localparam int PRIME_STAGES = 3;

	////////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [7:0] RST_RISE_EN = 8'h00;
	localparam logic [7:0] RST_FALL_EN = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [0:0] RST_IRQ_STATUS = 1'h0;
	localparam logic [0:0] RST_IRQ_MASK = 1'h0;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// Bus request as seen by the slave
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [ADR_WIDTH-1:0] adr;
		logic [DAT_WIDTH-1:0] dat;
	} pcg_wb_req_type;

	// Whole state of the block
	typedef struct packed {
		logic [PORT_WIDTH-1:0] rise_edge_enable;
		logic [PORT_WIDTH-1:0] fall_edge_enable;
		logic [PORT_WIDTH-1:0] pin_change_flag;
		logic [0:0] irq_status;
		logic [0:0] irq_mask;
		logic [PORT_WIDTH-1:0] sync_meta;
		logic [PORT_WIDTH-1:0] sync_pin;
		logic [PORT_WIDTH-1:0] prev_pin;
		logic [PRIME_STAGES-1:0] primed;
		logic ack;
		logic [DAT_WIDTH-1:0] rdat;
		logic irq;
		logic change_req;
	} pcg_state_type;

endpackage

/* hw/pcg_top.sv */
// Pin change interrupt logic: edge detect on eight watched pins, Wishbone registers.
// Assumes pins are asynchronous to i_clk and the bus master is classic Wishbone.
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module pcg_top (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [pcg_pkg::PORT_WIDTH-1:0] i_watched_port_pin,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [3:0] i_wb_sel,
	input wire logic [pcg_pkg::ADR_WIDTH-1:0] i_wb_adr,
	input wire logic [pcg_pkg::DAT_WIDTH-1:0] i_wb_dat,
	output logic [pcg_pkg::DAT_WIDTH-1:0] o_wb_dat,
	output logic o_wb_ack,
	output logic o_irq,
	output logic o_change_req
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	pcg_pkg::pcg_state_type st_q;
	pcg_pkg::pcg_state_type st_d;
	pcg_pkg::pcg_wb_req_type req;
	logic [pcg_pkg::PORT_WIDTH-1:0] rise_seen;
	logic [pcg_pkg::PORT_WIDTH-1:0] fall_seen;
	logic [pcg_pkg::PORT_WIDTH-1:0] rise_hit;
	logic [pcg_pkg::PORT_WIDTH-1:0] fall_hit;
	logic [pcg_pkg::PORT_WIDTH-1:0] any_hit;
	logic access;
	logic wr_lane0;
	logic wr_rise;
	logic wr_fall;
	logic wr_flags;
	logic wr_status;
	logic wr_mask;
	logic [7:0] wbyte;
	logic [7:0] word_adr;
	logic armed;

	assign req.cyc = i_wb_cyc;
	assign req.stb = i_wb_stb;
	assign req.we = i_wb_we;
	assign req.sel = i_wb_sel;
	assign req.adr = i_wb_adr;
	assign req.dat = i_wb_dat;

	////////////////////////////////////////////////////////////////////////////
	// Edge detection
	// Armed once the previous sample holds a real pin level, so a pin high at reset
	// never looks like a rise
	assign armed = st_q.primed[pcg_pkg::PRIME_STAGES-1];
	assign rise_seen = armed ? (st_q.sync_pin & ~st_q.prev_pin) : '0;
	assign fall_seen = armed ? (~st_q.sync_pin & st_q.prev_pin) : '0;
	assign rise_hit = rise_seen & st_q.rise_edge_enable;
	assign fall_hit = fall_seen & st_q.fall_edge_enable;
	assign any_hit = rise_hit | fall_hit;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	assign access = req.cyc & req.stb & ~st_q.ack;
	assign wr_lane0 = access & req.we & req.sel[0];
	assign word_adr = {req.adr[7:2], 2'b00};
	assign wbyte = req.dat[7:0];
	assign wr_rise = wr_lane0 && (word_adr == pcg_pkg::ADR_RISE_EN);
	assign wr_fall = wr_lane0 && (word_adr == pcg_pkg::ADR_FALL_EN);
	assign wr_flags = wr_lane0 && (word_adr == pcg_pkg::ADR_FLAGS);
	assign wr_status = wr_lane0 && (word_adr == pcg_pkg::ADR_IRQ_STATUS);
	assign wr_mask = wr_lane0 && (word_adr == pcg_pkg::ADR_IRQ_MASK);

	////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_d = st_q;
		// Only the second stage feeds logic
		st_d.sync_meta = i_watched_port_pin;
		st_d.sync_pin = st_q.sync_meta;
		st_d.prev_pin = st_q.sync_pin;
		st_d.primed = {st_q.primed[pcg_pkg::PRIME_STAGES-2:0], 1'b1};

		if (wr_rise) begin
			st_d.rise_edge_enable = wbyte;
		end
		if (wr_fall) begin
			st_d.fall_edge_enable = wbyte;
		end

		// Written value replaces the flags, a new edge wins over a clear
		if (wr_flags) begin
			st_d.pin_change_flag = wbyte | any_hit;
		end else begin
			st_d.pin_change_flag = st_q.pin_change_flag | rise_hit | fall_hit;
		end

		// Module flag is write one to clear, set wins
		if (wr_status && wbyte[pcg_pkg::IRQ_CHANGE_BIT]) begin
			st_d.irq_status = 1'b0;
		end
		if (|any_hit) begin
			st_d.irq_status = 1'b1;
		end
		if (wr_mask) begin
			st_d.irq_mask = wbyte[0:0];
		end

		st_d.ack = access;
		if (access) begin
			unique case (word_adr)
				pcg_pkg::ADR_RISE_EN: st_d.rdat = {24'h00_0000, st_q.rise_edge_enable};
				pcg_pkg::ADR_FALL_EN: st_d.rdat = {24'h00_0000, st_q.fall_edge_enable};
				pcg_pkg::ADR_FLAGS: st_d.rdat = {24'h00_0000, st_q.pin_change_flag};
				pcg_pkg::ADR_IRQ_STATUS: st_d.rdat = {31'h0000_0000, st_q.irq_status};
				pcg_pkg::ADR_IRQ_MASK: st_d.rdat = {31'h0000_0000, st_q.irq_mask};
				default: st_d.rdat = pcg_pkg::RD_UNMAPPED;
			endcase
		end else begin
			st_d.rdat = pcg_pkg::RD_UNMAPPED;
		end

		st_d.irq = |(st_d.irq_status & st_d.irq_mask);
		st_d.change_req = |st_d.pin_change_flag;
	end

	////////////////////////////////////////////////////////////////////////////
	// State register, frozen while the clock enable is low
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q.rise_edge_enable <= pcg_pkg::RST_RISE_EN;
			st_q.fall_edge_enable <= pcg_pkg::RST_FALL_EN;
			st_q.pin_change_flag <= pcg_pkg::RST_FLAGS;
			st_q.irq_status <= pcg_pkg::RST_IRQ_STATUS;
			st_q.irq_mask <= pcg_pkg::RST_IRQ_MASK;
			st_q.sync_meta <= '0;
			st_q.sync_pin <= '0;
			st_q.prev_pin <= '0;
			st_q.primed <= '0;
			st_q.ack <= 1'b0;
			st_q.rdat <= pcg_pkg::RD_UNMAPPED;
			st_q.irq <= 1'b0;
			st_q.change_req <= 1'b0;
		end else if (i_ce) begin
			st_q <= st_d;
		end
	end

	assign o_wb_dat = st_q.rdat;
	assign o_wb_ack = st_q.ack;
	assign o_irq = st_q.irq;
	assign o_change_req = st_q.change_req;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	a_rise_sets_flag: assert property (
		(i_ce && |rise_hit) |=>
			((st_q.pin_change_flag & $past(rise_hit)) == $past(rise_hit))
	) else $error("rising edge did not set its flag");

	a_fall_sets_flag: assert property (
		(i_ce && |fall_hit) |=>
			((st_q.pin_change_flag & $past(fall_hit)) == $past(fall_hit))
	) else $error("falling edge did not set its flag");

	a_rise_detect: assert property (
		(i_ce && armed && st_q.rise_edge_enable[0] && st_q.sync_pin[0]
			&& !st_q.prev_pin[0]) |=> st_q.pin_change_flag[0]
	) else $error("enabled rise on pin 0 missed");

	a_fall_detect: assert property (
		(i_ce && armed && st_q.fall_edge_enable[7] && !st_q.sync_pin[7]
			&& st_q.prev_pin[7]) |=> st_q.pin_change_flag[7]
	) else $error("enabled fall on pin 7 missed");

	a_no_masked_set: assert property (
		(i_ce && !wr_flags) |=>
			((st_q.pin_change_flag & ~$past(st_q.pin_change_flag) & ~$past(any_hit)) == 8'h00)
	) else $error("flag set without an enabled edge");

	a_module_flag: assert property (
		(i_ce && |any_hit) |=> (st_q.irq_status[0] && st_q.change_req)
	) else $error("module change flag not set on edge");

	a_flag_clear: assert property (
		(i_ce && wr_flags) |=>
			((st_q.pin_change_flag & ~($past(wbyte) | $past(any_hit))) == 8'h00)
	) else $error("written zero did not clear flag");

	a_clear_holds: assert property (
		(i_ce && wr_flags && wbyte[3] == 1'b0 && !any_hit[3]) ##1
			(!i_ce || !any_hit[3]) [*2] |-> !st_q.pin_change_flag[3]
	) else $error("cleared flag came back without an edge");

	a_reset_zero: assert property (@(posedge i_clk) disable iff (1'b0)
		i_rst |-> (st_q.rise_edge_enable == 8'h00 && st_q.fall_edge_enable == 8'h00
			&& st_q.pin_change_flag == 8'h00 && !o_irq && !o_wb_ack)
	) else $error("register not zero during reset");

	a_sync_latency: assert property (
		(i_ce && armed && $changed(i_watched_port_pin[0])) ##1 i_ce ##1 i_ce
			|-> (st_q.sync_pin[0] == $past(i_watched_port_pin[0], 2))
	) else $error("pin sample not two stages late");

	a_req_is_or: assert property (
		$rose(o_change_req) |-> ($past(st_q.pin_change_flag) == 8'h00
			&& st_q.pin_change_flag != 8'h00)
	) else $error("change request not the OR of flags");

	a_ack_single: assert property (
		o_wb_ack |=> !o_wb_ack
	) else $error("ack held longer than one cycle");

	a_irq_level: assert property (
		(i_ce && st_q.irq_status[0] && st_q.irq_mask[0] && !wr_status && !wr_mask) |=>
			o_irq
	) else $error("unmasked status did not raise interrupt");

	a_ack_follows: assert property (
		(i_ce && access) |=>
			o_wb_ack
	) else $error("bus request not acknowledged in one cycle");

	a_ack_needs_req: assert property (
		(i_ce && !access) |=>
			!o_wb_ack
	) else $error("ack without a new request");

	a_idle_data_zero: assert property (
		!o_wb_ack |->
			(o_wb_dat == pcg_pkg::RD_UNMAPPED)
	) else $error("read data not zero outside ack");

	a_rise_en_write: assert property (
		(i_ce && wr_rise) |=>
			(st_q.rise_edge_enable == $past(wbyte))
	) else $error("rise enable write did not land");

	a_fall_en_write: assert property (
		(i_ce && wr_fall) |=>
			(st_q.fall_edge_enable == $past(wbyte))
	) else $error("fall enable write did not land");

	a_read_rise: assert property (
		(i_ce && access && !req.we && word_adr == pcg_pkg::ADR_RISE_EN) |=>
			(o_wb_dat == {24'h00_0000, $past(st_q.rise_edge_enable)})
	) else $error("rise enable read wrong");

	a_read_flags: assert property (
		(i_ce && access && !req.we && word_adr == pcg_pkg::ADR_FLAGS) |=>
			(o_wb_dat == {24'h00_0000, $past(st_q.pin_change_flag)})
	) else $error("flag read wrong");

	a_sel_ignored: assert property (
		(i_ce && access && req.we && !req.sel[0]) |=>
			($stable(st_q.rise_edge_enable) && $stable(st_q.fall_edge_enable))
	) else $error("write without low lane changed a register");

	a_ce_freeze: assert property (
		!i_ce |=>
			$stable(st_q)
	) else $error("state moved while clock enable low");

	a_unarmed_quiet: assert property (
		!armed |->
			(any_hit == 8'h00)
	) else $error("edge seen before samples were valid");

	a_req_follows: assert property (
		i_ce |=>
			(o_change_req == (st_q.pin_change_flag != 8'h00))
	) else $error("change request differs from flag OR");

	a_flag_sticky: assert property (
		(i_ce && !wr_flags) |=>
			((st_q.pin_change_flag & $past(st_q.pin_change_flag)) == $past(st_q.pin_change_flag))
	) else $error("flag dropped without a write");

	a_status_clear: assert property (
		(i_ce && wr_status && wbyte[pcg_pkg::IRQ_CHANGE_BIT] && any_hit == 8'h00) |=>
			!st_q.irq_status[0]
	) else $error("status write one did not clear");

	a_status_sticky: assert property (
		(i_ce && st_q.irq_status[0] && !wr_status) |=>
			st_q.irq_status[0]
	) else $error("status dropped without a write");

	a_no_irq_masked: assert property (
		(i_ce && !st_q.irq_mask[0] && !wr_mask) |=>
			!o_irq
	) else $error("interrupt raised while masked");

	a_mask_write: assert property (
		(i_ce && wr_mask) |=>
			(st_q.irq_mask[0] == $past(wbyte[0]))
	) else $error("mask write did not land");

	c_rise_event: cover property (i_ce && |rise_hit ##1 o_change_req);
	c_fall_event: cover property (i_ce && |fall_hit ##1 o_change_req);
	c_flag_clear: cover property (o_change_req ##1 (i_ce && wr_flags && wbyte == 8'h00)
		##1 !o_change_req);
	c_irq_out: cover property ($rose(o_irq));
	c_ce_freeze: cover property (!i_ce && o_change_req);

endmodule

`default_nettype wire

/* tb/pcg_pins.sv */
// Far-side model: the eight external input pins watched by the block.
// Assumes the bench asks for pin levels; they change just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none

module pcg_pins (
	input wire logic i_clk,
	input wire logic [7:0] i_level,
	output logic [7:0] o_pin
);
	// Pins are plain driven levels, no release, so no float pattern needed
	always_ff @(posedge i_clk) begin
		o_pin <= i_level;
	end
endmodule
`default_nettype wire

/* tb/pcg_top_test.sv */
// Self-checking bench: bus tasks, pin model and a reference model of flags.
// Assumes the pcg_pkg package and the pcg_pins far-side model are compiled first.
`timescale 1ns/10ps
`default_nettype none

module pcg_top_test;
	logic i_clk, i_rst, ce, cyc, stb, we, st, m;
	logic [3:0] sel, lanes;
	logic [7:0] adr, lvl, pins, re, fe, fl, prev, ev, v;
	logic [31:0] dat, o_wb_dat, rd;
	logic o_wb_ack, o_irq, o_change_req;
	int mismatches, total_checks, seed, cycles;

	pcg_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_watched_port_pin(pins),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_sel(sel), .i_wb_adr(adr),
		.i_wb_dat(dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_irq(o_irq),
		.o_change_req(o_change_req));
	pcg_pins pins_model (.i_clk(i_clk), .i_level(lvl), .o_pin(pins));

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Whole run is well under this; a hung ack loop ends here
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	// Entered just after a rising edge; request held until ack is seen at an edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= lanes;
		adr <= a;
		dat <= d;
		@(posedge i_clk);
		while (o_wb_ack !== 1'b1) @(posedge i_clk);
		rd = o_wb_dat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(n, rd, e);
	endtask

	// New random pin levels, then enough edges for sync and flag update
	task automatic pinstep(input bit freeze);
		v = 8'($random(seed));
		lvl <= v;
		if (freeze) begin
			ce <= 1'b0;
			repeat (6) @(posedge i_clk);
			chk("ce_freeze", {31'h0, o_change_req}, {31'h0, |fl});
			ce <= 1'b1;
		end
		repeat (5) @(posedge i_clk);
		ev = (re & v & ~prev) | (fe & ~v & prev);
		fl = fl | ev;
		st = st | (|ev);
		prev = v;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 17;
		i_rst = 1'b1;
		{cyc, stb, we, sel, adr, dat, lvl} = '0;
		ce = 1'b1;
		lanes = 4'hf;
		{fl, prev, st, m, mismatches, total_checks, cycles} = '0;
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		wb(1'b1, 8'h14, 32'hffff_ffff);
		for (int a = 0; a < 24; a += 4) rdchk("reset", a[7:0], 32'h0);
		re = 8'($random(seed));
		fe = 8'($random(seed));
		wb(1'b1, pcg_pkg::ADR_RISE_EN, {24'h0, re});
		wb(1'b1, pcg_pkg::ADR_FALL_EN, {24'h0, fe});
		rdchk("rise_en", pcg_pkg::ADR_RISE_EN, {24'h0, re});
		rdchk("fall_en", pcg_pkg::ADR_FALL_EN, {24'h0, fe});
		m = 1'b1;
		wb(1'b1, pcg_pkg::ADR_IRQ_MASK, 32'h1);
		for (int i = 0; i < 16; i++) begin
			pinstep(i == 5);
			rdchk("flags", pcg_pkg::ADR_FLAGS, {24'h0, fl});
			chk("change_req", {31'h0, o_change_req}, {31'h0, |fl});
			rdchk("status", pcg_pkg::ADR_IRQ_STATUS, {31'h0, st});
			chk("irq", {31'h0, o_irq}, {31'h0, st & m});
			if (i % 4 == 3) begin
				v = 8'($random(seed));
				wb(1'b1, pcg_pkg::ADR_FLAGS, {24'h0, v});
				fl = v;
				rdchk("flag_write", pcg_pkg::ADR_FLAGS, {24'h0, fl});
				wb(1'b1, pcg_pkg::ADR_FLAGS, 32'h0);
				fl = 8'h00;
				rdchk("flag_clear", pcg_pkg::ADR_FLAGS, 32'h0);
				wb(1'b1, pcg_pkg::ADR_IRQ_STATUS, 32'h1);
				st = 1'b0;
				m = (i < 8);
				wb(1'b1, pcg_pkg::ADR_IRQ_MASK, {31'h0, m});
				chk("irq_clear", {31'h0, o_irq}, 32'h0);
			end
		end
		// Mid-run reset with pins left at their level: no false edge, all back to zero
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		chk("rst_req", {31'h0, o_change_req}, 32'h0);
		chk("rst_irq", {31'h0, o_irq}, 32'h0);
		for (int a = 0; a < 20; a += 4) rdchk("rst_regs", a[7:0], 32'h0);
		fl = 8'h00;
		st = 1'b0;
		m = 1'b0;
		re = 8'hff;
		fe = 8'hff;
		wb(1'b1, pcg_pkg::ADR_RISE_EN, {24'h0, re});
		wb(1'b1, pcg_pkg::ADR_FALL_EN, {24'h0, fe});
		repeat (4) @(posedge i_clk);
		rdchk("rst_no_edge", pcg_pkg::ADR_FLAGS, 32'h0);
		lanes = 4'he;
		wb(1'b1, pcg_pkg::ADR_RISE_EN, 32'h0);
		lanes = 4'hf;
		rdchk("lane_off", pcg_pkg::ADR_RISE_EN, {24'h0, re});
		pinstep(1'b0);
		rdchk("post_rst", pcg_pkg::ADR_FLAGS, {24'h0, fl});
		chk("post_rst_req", {31'h0, o_change_req}, {31'h0, |fl});
		end_of_test();
	end
endmodule
`default_nettype wire
